/* File: rtl/rdd_pkg.sv */
// Constants shared by the receive line decoder
package rdd_pkg;
	localparam logic [6:0] ADDR_QUEUE     = 7'h00;
	localparam logic [6:0] ADDR_RATE_HIGH = 7'h03;
	localparam logic [6:0] ADDR_RATE_LOW  = 7'h04;
	localparam logic [6:0] ADDR_PKT_CFG_A = 7'h37;
	localparam logic [6:0] ADDR_STATUS    = 7'h50;
	localparam logic [7:0] RESET_RATE_HIGH = 8'h1a;
	localparam logic [7:0] RESET_RATE_LOW  = 8'h0b;
	localparam logic [7:0] RESET_PKT_CFG_A = 8'h10;
	localparam int SEL_POS = 5;
	localparam logic [1:0] SEL_NRZ        = 2'h0;
	localparam logic [1:0] SEL_MANCHESTER = 2'h1;
	localparam logic [1:0] SEL_WHITENING  = 2'h2;
	localparam logic [8:0] LFSR_SEED = 9'h1ff;
	localparam int LFSR_TAP = 5;
	localparam logic [7:0] CHECKSUM_BYTES = 8'h02;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int ST_NOT_EMPTY = 0;
	localparam int ST_FULL      = 1;
	localparam int ST_OVERRUN   = 2;
	localparam int ST_BUSY      = 3;
	typedef enum logic [1:0]
	{
		RDD_IDLE     = 2'b00,
		RDD_PAYLOAD  = 2'b01,
		RDD_CHECKSUM = 2'b11
	} rdd_state_type;
endpackage : rdd_pkg

/* File: rtl/rdd_decoder.sv */
// Receive DC-free line decoder with its receive queue
//
// Contract
// [RULE_01] Selection field value 01 turns on Manchester decoding of received data.
// [RULE_02] Host picks Manchester only in packet mode, never in continuous modes.
// [RULE_03] Chip pair 10 decodes to one, chip pair 01 decodes to zero.
// [RULE_04] With Manchester on, user bit rate is half the chip rate.
// [RULE_05] Only payload and checksum are decoded; preamble and sync stay plain.
// [RULE_06] One chip rate from the rate setting for every field of the packet.
// [RULE_07] Only recovered data bytes enter the receive queue, never raw chips.
// [RULE_08] Selection field value 10 turns on de-whitening; results go to the queue.
// [RULE_09] Payload and both checksum bytes are XORed with a 9-bit LFSR sequence.
// [RULE_10] De-whitening keeps the rate: one output bit per received bit.
// [RULE_11] Host enables at most one DC-free method at a time.
// [RULE_12] The two checksum bytes are dropped; only payload bytes reach the queue.
// [RULE_13] LFSR uses x^9 + x^5 + 1, seeded all ones at payload start.
`timescale 1ns/10ps
`default_nettype none

module rdd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
		next_ptr = (ptr == AW'(DEPTH-1)) ? '0 : ptr + 1'b1;
	endfunction : next_ptr

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= next_ptr(wr_ptr);
			if (pop)
				rd_ptr <= next_ptr(rd_ptr);
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule : rdd_fifo

module rdd_decoder #(
	parameter int QUEUE_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Demodulated chip stream and packet framing
	input  wire logic        rx_chip,
	input  wire logic        sync_found,
	input  wire logic        packet_mode,
	input  wire logic [7:0]  payload_length,
	// Status
	output logic             chip_strobe,
	output logic             queue_not_empty,
	output logic             queue_overrun,
	output logic             packet_done,
	output logic      [15:0] checksum_word
);
	logic [7:0]                 chip_rate_high_byte;
	logic [7:0]                 chip_rate_low_byte;
	logic [7:0]                 packet_handler_config_a;
	logic [15:0]                chip_count;
	rdd_pkg::rdd_state_type     state;
	logic [1:0]                 line_decode_select;
	logic                       manchester;
	logic                       whitening;
	logic                       first_chip;
	logic                       half;
	logic                       bit_valid;
	logic                       bit_value;
	logic [8:0]                 lfsr;
	logic [7:0]                 shift;
	logic [2:0]                 bit_idx;
	logic [7:0]                 byte_idx;
	logic [7:0]                 next_byte;
	logic                       byte_done;
	logic                       pending;
	logic [7:0]                 pending_byte;
	logic                       fifo_ready;
	logic                       fifo_valid;
	logic [7:0]                 fifo_data;
	logic                       pop;

	// Divider gives the chip timing for every field of the packet
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chip_count  <= '0;
			chip_strobe <= 1'b0;
		end
		else if (chip_count + 16'h0001 >= {chip_rate_high_byte, chip_rate_low_byte})
		begin
			chip_count  <= '0; // [RULE_06]
			chip_strobe <= 1'b1;
		end
		else
		begin
			chip_count  <= chip_count + 16'h0001;
			chip_strobe <= 1'b0;
		end
	end

	assign line_decode_select = packet_handler_config_a[rdd_pkg::SEL_POS +: 2];
	assign manchester = packet_mode && (line_decode_select == rdd_pkg::SEL_MANCHESTER); // [RULE_01]
	assign whitening  = (line_decode_select == rdd_pkg::SEL_WHITENING); // [RULE_08]

	// Bit recovery from chips
	always_comb
	begin
		bit_valid = 1'b0;
		bit_value = rx_chip;
		if (chip_strobe && state != rdd_pkg::RDD_IDLE)
		begin
			if (manchester)
			begin
				bit_valid = half; // [RULE_04]
				// 10 gives one, 01 gives zero; a broken pair keeps its first chip
				bit_value = first_chip; // [RULE_03]
			end
			else
				bit_valid = 1'b1; // [RULE_10]
			if (whitening)
				bit_value = bit_value ^ lfsr[0]; // [RULE_09]
		end
	end

	assign next_byte = {shift[6:0], bit_value};
	assign byte_done = bit_valid && (bit_idx == rdd_pkg::LAST_BIT);

	// Packet sequencing; framing before sync is plain and never decoded
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state       <= rdd_pkg::RDD_IDLE;
			half        <= 1'b0;
			first_chip  <= 1'b0;
			bit_idx     <= '0;
			byte_idx    <= '0;
			shift       <= '0;
			packet_done <= 1'b0;
		end
		else
		begin
			packet_done <= 1'b0;
			if (sync_found)
			begin
				state    <= rdd_pkg::RDD_PAYLOAD; // [RULE_05]
				half     <= 1'b0;
				bit_idx  <= '0;
				byte_idx <= '0;
			end
			else
			begin
				if (chip_strobe && state != rdd_pkg::RDD_IDLE && manchester)
				begin
					half       <= !half;
					first_chip <= rx_chip;
				end
				if (bit_valid)
				begin
					shift   <= next_byte;
					bit_idx <= bit_idx + 3'h1;
				end
				if (byte_done)
				begin
					byte_idx <= byte_idx + 8'h01;
					if (state == rdd_pkg::RDD_PAYLOAD && byte_idx + 8'h01 == payload_length)
					begin
						state    <= rdd_pkg::RDD_CHECKSUM;
						byte_idx <= '0;
					end
					else if (state == rdd_pkg::RDD_CHECKSUM &&
						byte_idx + 8'h01 == rdd_pkg::CHECKSUM_BYTES)
					begin
						state       <= rdd_pkg::RDD_IDLE;
						packet_done <= 1'b1;
					end
				end
			end
		end
	end

	// De-whitening sequence
	always_ff @(posedge clk)
	begin
		if (rst || sync_found)
			lfsr <= rdd_pkg::LFSR_SEED; // [RULE_13]
		else if (bit_valid && whitening)
			lfsr <= {lfsr[0] ^ lfsr[rdd_pkg::LFSR_TAP], lfsr[8:1]}; // [RULE_13]
	end

	// Checksum bytes are kept aside, not queued
	always_ff @(posedge clk)
	begin
		if (rst)
			checksum_word <= '0;
		else if (byte_done && state == rdd_pkg::RDD_CHECKSUM)
			checksum_word <= {checksum_word[7:0], next_byte}; // [RULE_12]
	end

	// Holding stage in front of the queue; a second byte while it waits is an overrun
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pending       <= 1'b0;
			pending_byte  <= '0;
			queue_overrun <= 1'b0;
		end
		else
		begin
			if (byte_done && state == rdd_pkg::RDD_PAYLOAD)
			begin
				pending      <= 1'b1; // [RULE_07]
				pending_byte <= next_byte;
				if (pending && !fifo_ready)
					queue_overrun <= 1'b1;
			end
			else if (pending && fifo_ready)
				pending <= 1'b0;
			if (reg_write && reg_addr == rdd_pkg::ADDR_STATUS && reg_wdata[rdd_pkg::ST_OVERRUN]
				&& !(byte_done && state == rdd_pkg::RDD_PAYLOAD && pending && !fifo_ready))
				queue_overrun <= 1'b0;
		end
	end

	rdd_fifo #(
		.WIDTH (8),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (pending),
		.in_data   (pending_byte),
		.in_ready  (fifo_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (pop)
	);

	assign pop = reg_read && reg_addr == rdd_pkg::ADDR_QUEUE;

	// Configuration writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chip_rate_high_byte     <= rdd_pkg::RESET_RATE_HIGH;
			chip_rate_low_byte      <= rdd_pkg::RESET_RATE_LOW;
			packet_handler_config_a <= rdd_pkg::RESET_PKT_CFG_A;
		end
		else if (reg_write)
		begin
			case (reg_addr)
				rdd_pkg::ADDR_RATE_HIGH: chip_rate_high_byte     <= reg_wdata;
				rdd_pkg::ADDR_RATE_LOW:  chip_rate_low_byte      <= reg_wdata;
				rdd_pkg::ADDR_PKT_CFG_A: packet_handler_config_a <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Register reads; the data port pops one decoded byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata       <= '0;
			queue_not_empty <= 1'b0;
		end
		else
		begin
			queue_not_empty <= fifo_valid;
			if (reg_read)
			begin
				case (reg_addr)
					rdd_pkg::ADDR_QUEUE:     reg_rdata <= fifo_valid ? fifo_data : 8'h00;
					rdd_pkg::ADDR_RATE_HIGH: reg_rdata <= chip_rate_high_byte;
					rdd_pkg::ADDR_RATE_LOW:  reg_rdata <= chip_rate_low_byte;
					rdd_pkg::ADDR_PKT_CFG_A: reg_rdata <= packet_handler_config_a;
					rdd_pkg::ADDR_STATUS:
						reg_rdata <= {4'h0, state != rdd_pkg::RDD_IDLE, queue_overrun,
							!fifo_ready, fifo_valid};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : rdd_decoder

`default_nettype wire

/* File: tb/rdd_decoder_properties.sv */
// Port checks for the receive line decoder
`timescale 1ns/10ps
`default_nettype none
module rdd_decoder_properties #(
	parameter int QUEUE_DEPTH = 16
) (
	// Clock and reset
	input wire logic		clk,
	input wire logic		rst,
	// Registers
	input wire logic [6:0]	reg_addr,
	input wire logic		reg_write,
	input wire logic		reg_read,
	input wire logic [7:0]	reg_wdata,
	input wire logic [7:0]	reg_rdata,
	// Link
	input wire logic		rx_chip,
	input wire logic		sync_found,
	input wire logic		packet_mode,
	input wire logic [7:0]	payload_length,
	// Status
	input wire logic		chip_strobe,
	input wire logic		queue_not_empty,
	input wire logic		queue_overrun,
	input wire logic		packet_done,
	input wire logic [15:0]	checksum_word
);
	logic pop;
	assign pop = reg_read && reg_addr == 7'h00;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_read && !(reg_addr inside
		{7'h00, 7'h03, 7'h04, 7'h37, 7'h50}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_reset_clear: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00
		&& !packet_done && !queue_overrun && !queue_not_empty)
		else $error("outputs not cleared by reset");
	a_done_pulse: assert property (packet_done |=> !packet_done)
		else $error("done longer than one cycle");
	a_overrun_sticky: assert property (queue_overrun && !(reg_write && reg_addr == 7'h50)
		|=> queue_overrun) else $error("overrun flag lost");
	a_cfg_readback: assert property (reg_write && reg_addr == 7'h37 ##1 !reg_write
		##1 reg_read && reg_addr == 7'h37 |=> reg_rdata == $past(reg_wdata, 3))
		else $error("config readback wrong");
	a_cksum_hold: assert property (packet_done |=> $stable(checksum_word) [*4])
		else $error("checksum moved after done");
	a_pop_fall: assert property ($fell(queue_not_empty) |-> $past(pop) || $past(pop, 2))
		else $error("queue emptied without a read");
endmodule : rdd_decoder_properties
bind rdd_decoder rdd_decoder_properties #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u (.clk(clk),
	.rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_chip(rx_chip), .sync_found(sync_found),
	.packet_mode(packet_mode), .payload_length(payload_length), .chip_strobe(chip_strobe),
	.queue_not_empty(queue_not_empty), .queue_overrun(queue_overrun),
	.packet_done(packet_done), .checksum_word(checksum_word));
`default_nettype wire

/* File: tb/rdd_tx_model.sv */
// Remote transmitter model feeding coded chips
`timescale 1ns/10ps
`default_nettype none
module rdd_tx_model (
	// Clock and reset
	input wire logic			clk,
	input wire logic			rst,
	// Frame to send
	input wire logic			load,
	input wire logic [511:0]	chips,
	input wire logic [8:0]		nchips,
	// Link
	input wire logic			chip_strobe,
	output logic				rx_chip
);
	logic [511:0]	frame;
	logic [8:0]		left;
	logic			junk;
	// Oldest chip first; an idle line toggles so stale values never look valid
	assign rx_chip = (left != 9'h0) ? frame[left - 9'h1] : junk;
	always_ff @(posedge clk)
	begin
		junk <= rst ? 1'b0 : ~junk;
		if (rst)
			left <= 9'h0;
		else if (load)
			{frame, left} <= {chips, nchips};
		else if (chip_strobe && left != 9'h0)
			left <= left - 9'h1;
	end
endmodule : rdd_tx_model
`default_nettype wire

/* File: tb/tb_rx_dc_free_decoder.sv */
// Self-checking bench for the receive line decoder
`timescale 1ns/10ps
`default_nettype none
module tb_rx_dc_free_decoder;
	logic			clk = 0, rst = 1, reg_write = 0, reg_read = 0, sync_found = 0, load = 0;
	logic [6:0]		reg_addr = 0;
	logic [7:0]		reg_wdata = 0, reg_rdata, payload_length = 0, got;
	logic			rx_chip, chip_strobe, queue_not_empty, queue_overrun, packet_done;
	logic [15:0]	checksum_word;
	logic [511:0]	chips = 0;
	logic			packet_mode = 1;
	logic [8:0]		nchips = 0, lf;
	logic [7:0]		dat [0:21];
	int				err_total = 0, tests_run = 0;
	always #25 clk = ~clk;
	rdd_decoder #(.QUEUE_DEPTH(16)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rx_chip(rx_chip), .sync_found(sync_found),
		.packet_mode(packet_mode), .payload_length(payload_length), .chip_strobe(chip_strobe),
		.queue_not_empty(queue_not_empty), .queue_overrun(queue_overrun),
		.packet_done(packet_done), .checksum_word(checksum_word));
	rdd_tx_model partner_u (.clk(clk), .rst(rst), .load(load), .chips(chips),
		.nchips(nchips), .chip_strobe(chip_strobe), .rx_chip(rx_chip));
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Status after a packet: busy clear, overrun past 17 bytes, full from 16
	function automatic logic [7:0] exp_status(input logic [7:0] n);
		exp_status = {5'h00, n > 8'h11, n >= 8'h10, 1'b1};
	endfunction : exp_status
	// One idle cycle after each access so a strobe never drops and rises at once
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
		@(negedge clk);
		reg_write = 0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [6:0] a);
		{reg_addr, reg_read} = {a, 1'b1};
		@(negedge clk);
		reg_read = 0;
		got = reg_rdata;
		@(negedge clk);
	endtask : rd
	task automatic run(input logic [1:0] m, input logic [7:0] n);
		int k;
		logic b;
		packet_mode = (m != 2'h0);
		wr(rdd_pkg::ADDR_PKT_CFG_A, {1'b0, m, 5'h10});
		rd(rdd_pkg::ADDR_PKT_CFG_A);
		check(got, {1'b0, m, 5'h10});
		lf = rdd_pkg::LFSR_SEED;
		nchips = 0;
		for (k = 0; k < (n + 2) * 8; k++)
		begin
			if (k % 8 == 0)
				dat[k / 8] = 8'($urandom);
			b = dat[k / 8][7 - k % 8] ^ (m == 2'h2 && lf[0]);
			lf = {lf[0] ^ lf[5], lf[8:1]};
			chips = (m == 2'h1) ? {chips[509:0], b, ~b} : {chips[510:0], b};
			nchips = nchips + 9'd1 + 9'(m == 2'h1);
		end
		{payload_length, sync_found, load} = {n, 2'b11};
		@(negedge clk);
		{sync_found, load} = 2'b00;
		for (k = 0; k < 3000 && packet_done !== 1'b1; k++)
			@(negedge clk);
		check(packet_done, 1);
		check(16'((k - 1) / 4 == nchips - 1), 1);
		check(checksum_word, {dat[n], dat[n + 1]});
		check(queue_overrun, 16'(n > 17));
		rd(rdd_pkg::ADDR_STATUS);
		check(got, exp_status(n));
		for (k = 0; k < n; k++)
		begin
			rd(rdd_pkg::ADDR_QUEUE);
			if (k < 16)
				check(got, dat[k]);
			else
				check(got, (k == 16) ? dat[n - 1] : 8'h00);
		end
		wr(rdd_pkg::ADDR_STATUS, 8'h04);
		@(negedge clk);
		check({queue_overrun, queue_not_empty}, 0);
		$display("test mode %0d length %0d done", m, n);
	endtask : run
	initial
	begin
		void'($urandom(61822));
		repeat (3) @(negedge clk);
		rst = 0;
		rd(rdd_pkg::ADDR_RATE_HIGH);
		check(got, rdd_pkg::RESET_RATE_HIGH);
		rd(rdd_pkg::ADDR_RATE_LOW);
		check(got, rdd_pkg::RESET_RATE_LOW);
		rd(rdd_pkg::ADDR_PKT_CFG_A);
		check(got, rdd_pkg::RESET_PKT_CFG_A);
		rd(7'h05);
		check(got, 0);
		rd(rdd_pkg::ADDR_QUEUE);
		check(got, 0);
		$display("test register reset done");
		wr(rdd_pkg::ADDR_RATE_HIGH, 8'h00);
		wr(rdd_pkg::ADDR_RATE_LOW, 8'h04);
		for (int i = 0; i < 4; i++)
			run(2'(i), 8'(1 + $urandom % 4));
		run(2'h1, 8'h10);
		run(2'h0, 8'h14);
		close_out();
	end
	initial
	begin
		#2000000;
		err_total++;
		close_out();
	end
endmodule : tb_rx_dc_free_decoder
`default_nettype wire
